// *** bpm_params.svh ***
`ifndef BPM_PARAMS_SVH
`define BPM_PARAMS_SVH
`define BPM_CLK_HZ          40000000
`define BPM_CUR_PERIOD_US   3000
`define BPM_VOLT_PERIOD_US  63000
`define BPM_IDLE_CC_PERIOD_US 12000
`define BPM_SEC_US          1000000
`define BPM_US_CYCLES(us)   (((us) * (`BPM_CLK_HZ / 1000000)))
`define BPM_SLOW_ACT_HZ     262144
`define BPM_SLOW_IDLE_HZ    32768
`define BPM_FAST_HZ         16780000
`define BPM_CW              26
`endif

// *** bpm_pkg.sv ***
package bpm_pkg;
	typedef enum logic [2:0] {
		BPM_INIT,
		BPM_ACTIVE,
		BPM_IDLE,
		BPM_DEEP,
		BPM_OFF,
		BPM_UPDATE
	} bpm_mode_t;
	typedef enum logic [1:0] {
		BPM_DSG_OFF,
		BPM_DSG_PUMP,
		BPM_DSG_FOLLOW
	} bpm_dsg_t;
endpackage : bpm_pkg

// *** bpm_mode_ctrl.sv ***
`timescale 1ns/10ps
`include "bpm_params.svh"
module bpm_mode_ctrl #(
	parameter int CW               = `BPM_CW,
	parameter int CUR_CYCLES       = `BPM_US_CYCLES(`BPM_CUR_PERIOD_US),
	parameter int VOLT_CYCLES      = `BPM_US_CYCLES(`BPM_VOLT_PERIOD_US),
	parameter int IDLE_CC_CYCLES   = `BPM_US_CYCLES(`BPM_IDLE_CC_PERIOD_US),
	parameter int SEC_CYCLES       = `BPM_US_CYCLES(`BPM_SEC_US),
	parameter int CURW             = 16
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                init_done,
	input  wire logic                idle_permit_strap,
	input  wire logic                cmd_idle_allow,
	input  wire logic                cmd_idle_forbid,
	input  wire logic                cmd_idle_exit,
	input  wire logic                cmd_deep_enter,
	input  wire logic                cmd_deep_exit,
	input  wire logic                cmd_shutdown,
	input  wire logic                cmd_update_enter,
	input  wire logic                cmd_update_exit,
	input  wire logic                fast_conv_en,
	input  wire logic [2:0]          volt_period_mult,
	input  wire logic [7:0]          idle_interval_sec,
	input  wire logic [7:0]          hyst_sec,
	input  wire logic [CURW-1:0]     relax_thresh,
	input  wire logic [CURW-1:0]     wake_thresh,
	input  wire logic [CURW-1:0]     coarse_current_sample,
	input  wire logic [CURW-1:0]     idle_cc_sample,
	input  wire logic                idle_cc_valid,
	input  wire logic [CURW-1:0]     pack_voltage,
	input  wire logic [CURW-1:0]     stack_voltage,
	input  wire logic [CURW-1:0]     pack_delta,
	input  wire logic [CURW-1:0]     stack_thresh,
	input  wire logic                protection_fault,
	input  wire logic                charger_attach_pin,
	input  wire logic                rst_shut_pin,
	input  wire logic                idle_dsg_follow,
	input  wire logic                idle_chg_on,
	input  wire logic                deep_slow_osc_on,
	input  wire logic                deep_regs_on,
	input  wire logic                fast_osc_req,
	output bpm_pkg::bpm_mode_t       mode,
	output logic                     idle_permitted,
	output logic                     idle_active,
	output logic                     cur_sample_go,
	output logic                     volt_sample_go,
	output logic                     fine_sample_go,
	output logic                     temp_eval_go,
	output logic                     comparators_en,
	output logic                     measure_en,
	output bpm_pkg::bpm_dsg_t        discharge_switch,
	output logic                     charge_switch,
	output logic                     precharge_switch,
	output logic                     predischarge_switch,
	output logic                     slow_oscillator_en,
	output logic                     slow_oscillator_fast,
	output logic                     fast_oscillator_en,
	output logic                     aux_regulator_one,
	output logic                     aux_regulator_two,
	output logic                     settings_lost
);
	import bpm_pkg::*;

	logic [1:0]     chg_sync;
	logic [1:0]     rst_sync;
	logic           rst_q;
	logic [CW-1:0]  pin_cnt;
	logic           pin_short;
	logic           pin_long;
	bpm_mode_t      next_mode;
	logic           next_permit;
	logic           permit;
	logic           strap_taken;
	logic [CW-1:0]  sec_cnt;
	logic           sec_tick;
	logic [7:0]     iv_cnt;
	logic           iv_tick;
	logic [7:0]     hyst_cnt;
	logic [7:0]     next_hyst;
	logic           loop_wait;
	logic           next_loop_wait;
	logic [CW-1:0]  cur_cnt;
	logic [CW+2:0]  volt_cnt;
	logic [CW+2:0]  volt_lim;
	logic [CW-1:0]  cur_lim;
	logic           relaxed;
	logic           cur_flow;
	logic           pack_wake;
	logic           idle_exit;

	function automatic logic [CURW-1:0] mag(input logic [CURW-1:0] v);
		mag = v[CURW-1] ? CURW'(-v) : v;
	endfunction : mag

	// Pins pass two flops before use
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			chg_sync <= 2'h0;
			rst_sync <= 2'h0;
			rst_q    <= 1'b0;
		end else begin
			chg_sync <= {chg_sync[0], charger_attach_pin};
			rst_sync <= {rst_sync[0], rst_shut_pin};
			rst_q    <= rst_sync[1];
		end
	end

	// Pin pulse length: short releases wake idle, a full second shuts down
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) pin_cnt <= '0;
		else if (!rst_sync[1]) pin_cnt <= '0;
		else if (pin_cnt != CW'(SEC_CYCLES)) pin_cnt <= pin_cnt + 1'b1;
	end
	assign pin_long  = rst_sync[1] && (pin_cnt == CW'(SEC_CYCLES));
	assign pin_short = rst_q && !rst_sync[1] && (pin_cnt != CW'(SEC_CYCLES));

	// One-second time base and idle interval
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sec_cnt <= '0;
			iv_cnt  <= 8'h00;
		end else begin
			sec_cnt <= sec_tick ? '0 : sec_cnt + 1'b1;
			if (mode != BPM_IDLE) iv_cnt <= 8'h00;
			else if (iv_tick) iv_cnt <= 8'h00;
			else if (sec_tick) iv_cnt <= iv_cnt + 1'b1;
		end
	end
	assign sec_tick = (sec_cnt == CW'(SEC_CYCLES - 1));
	assign iv_tick  = sec_tick && (iv_cnt + 8'h01 >= idle_interval_sec);

	// Sample schedulers for active mode; the current counter also paces idle mode at IDLE_CC_CYCLES
	assign cur_lim  = fast_conv_en ? CW'(CUR_CYCLES / 2) : CW'(CUR_CYCLES);
	// Widen before adding so a multiplier of seven does not wrap to zero
	assign volt_lim = (CW+3)'(VOLT_CYCLES) * ((CW+3)'(volt_period_mult) + (CW+3)'(1))
		>> fast_conv_en;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur_cnt  <= '0;
			volt_cnt <= '0;
		end else begin
			cur_cnt  <= (mode == BPM_IDLE) ? ((cur_cnt >= CW'(IDLE_CC_CYCLES - 1)) ? '0
				: cur_cnt + 1'b1) : ((cur_cnt >= cur_lim - 1'b1) ? '0 : cur_cnt + 1'b1);
			volt_cnt <= (volt_cnt >= volt_lim - 1'b1) ? '0 : volt_cnt + 1'b1;
		end
	end

	// Wake conditions
	assign relaxed   = mag(coarse_current_sample) < relax_thresh;
	assign cur_flow  = (idle_cc_valid && mag(idle_cc_sample) > wake_thresh)
		|| (iv_tick && mag(coarse_current_sample) > wake_thresh);
	assign pack_wake = iv_tick && (pack_voltage > stack_voltage)
		&& (pack_voltage - stack_voltage > pack_delta)
		&& (stack_voltage < stack_thresh);
	assign idle_exit = protection_fault || cur_flow || chg_sync[1] || cmd_idle_exit
		|| pin_short || pack_wake;

	always_comb begin
		next_mode      = mode;
		next_permit    = permit;
		next_hyst      = (hyst_cnt != 8'h00 && sec_tick) ? hyst_cnt - 8'h01 : hyst_cnt;
		next_loop_wait = loop_wait && !sec_tick;
		if (cmd_idle_allow) next_permit = 1'b1;
		else if (cmd_idle_forbid) next_permit = 1'b0;
		case (mode)
			BPM_INIT: if (init_done) next_mode = BPM_ACTIVE;
			BPM_ACTIVE: begin
				if (cmd_update_enter) next_mode = BPM_UPDATE;
				else if (cmd_deep_enter) next_mode = BPM_DEEP;
				else if (relaxed && permit && hyst_cnt == 8'h00 && !protection_fault)
					next_mode = BPM_IDLE;
			end
			BPM_IDLE: begin
				if (cmd_deep_enter) next_mode = BPM_DEEP;
				else if (idle_exit) begin
					next_mode      = BPM_ACTIVE;
					next_hyst      = hyst_sec;
					next_loop_wait = cur_flow;
				end
			end
			BPM_DEEP: if (cmd_deep_exit || pin_short || chg_sync[1]) next_mode = BPM_ACTIVE;
			BPM_UPDATE: if (cmd_update_exit) next_mode = BPM_ACTIVE;
			BPM_OFF: next_mode = BPM_OFF;
			default: next_mode = BPM_INIT;
		endcase
		if (cmd_shutdown || pin_long) next_mode = BPM_OFF;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode        <= BPM_INIT;
			permit      <= 1'b0;
			strap_taken <= 1'b0;
			hyst_cnt    <= 8'h00;
			loop_wait   <= 1'b0;
		end else begin
			mode        <= next_mode;
			strap_taken <= strap_taken | init_done;
			permit      <= strap_taken ? next_permit : idle_permit_strap;
			hyst_cnt    <= next_hyst;
			loop_wait   <= next_loop_wait;
		end
	end

	// Outputs, all registered
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			idle_permitted      <= 1'b0;
			idle_active         <= 1'b0;
			cur_sample_go       <= 1'b0;
			volt_sample_go      <= 1'b0;
			fine_sample_go      <= 1'b0;
			temp_eval_go        <= 1'b0;
			comparators_en      <= 1'b0;
			measure_en          <= 1'b0;
			discharge_switch    <= BPM_DSG_OFF;
			charge_switch       <= 1'b0;
			precharge_switch    <= 1'b0;
			predischarge_switch <= 1'b0;
			slow_oscillator_en  <= 1'b0;
			slow_oscillator_fast <= 1'b0;
			fast_oscillator_en  <= 1'b0;
			aux_regulator_one   <= 1'b0;
			aux_regulator_two   <= 1'b0;
			settings_lost       <= 1'b0;
		end else begin
			idle_permitted <= permit;
			idle_active    <= (mode == BPM_IDLE);
			measure_en     <= (mode == BPM_ACTIVE) || (mode == BPM_IDLE);
			comparators_en <= (mode == BPM_ACTIVE) || (mode == BPM_IDLE);
			// Loop held off after a current wake until the second boundary
			cur_sample_go  <= (mode == BPM_ACTIVE) ? (!loop_wait && cur_cnt == '0)
				: (mode == BPM_IDLE) && cur_cnt == '0;
			volt_sample_go <= (mode == BPM_ACTIVE) ? (!loop_wait && volt_cnt == '0)
				: (mode == BPM_IDLE) && iv_tick;
			fine_sample_go <= (mode == BPM_ACTIVE) && !loop_wait && cur_cnt == '0;
			temp_eval_go   <= (mode == BPM_ACTIVE) ? (!loop_wait && volt_cnt == '0)
				: (mode == BPM_IDLE) && iv_tick;
			case (mode)
				BPM_ACTIVE: begin
					discharge_switch <= BPM_DSG_PUMP;
					charge_switch    <= 1'b1;
				end
				BPM_IDLE: begin
					discharge_switch <= idle_dsg_follow ? BPM_DSG_FOLLOW : BPM_DSG_PUMP;
					charge_switch    <= idle_chg_on;
				end
				default: begin
					discharge_switch <= BPM_DSG_OFF;
					charge_switch    <= 1'b0;
				end
			endcase
			// Precharge paths are owned elsewhere; this block only forces them off
			precharge_switch    <= 1'b0;
			predischarge_switch <= 1'b0;
			slow_oscillator_en  <= (mode == BPM_DEEP) ? deep_slow_osc_on
				: (mode != BPM_OFF);
			slow_oscillator_fast <= (mode != BPM_IDLE) && (mode != BPM_DEEP);
			fast_oscillator_en  <= fast_osc_req && (mode != BPM_OFF);
			aux_regulator_one   <= (mode == BPM_OFF) ? 1'b0
				: (mode == BPM_DEEP) ? deep_regs_on : 1'b1;
			aux_regulator_two   <= (mode == BPM_OFF) ? 1'b0
				: (mode == BPM_DEEP) ? deep_regs_on : 1'b1;
			settings_lost       <= (mode == BPM_OFF);
		end
	end
endmodule : bpm_mode_ctrl

// *** bpm_mode_asserts.sv ***
`timescale 1ns/10ps
module bpm_mode_asserts (
	input wire logic               clk,
	input wire logic               sys_rst,
	input wire logic               cmd_deep_enter,
	input wire logic               cmd_shutdown,
	input wire logic               protection_fault,
	input wire logic [7:0]         hyst_sec,
	input wire bpm_pkg::bpm_mode_t mode,
	input wire logic               idle_permitted,
	input wire logic               idle_active,
	input wire logic               comparators_en,
	input wire logic               measure_en,
	input wire bpm_pkg::bpm_dsg_t  discharge_switch,
	input wire logic               slow_oscillator_en,
	input wire logic               slow_oscillator_fast,
	input wire logic               aux_regulator_one,
	input wire logic               settings_lost
);
	import bpm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_deep_entry: assert property (
		mode == BPM_ACTIVE && cmd_deep_enter && !cmd_shutdown |=> mode == BPM_DEEP)
		else $error("deep idle not entered");
	chk_deep_quiet: assert property (
		(mode == BPM_DEEP)[*2] |-> !measure_en && !comparators_en
			&& discharge_switch == BPM_DSG_OFF) else $error("deep idle not quiet");
	chk_off_all: assert property (
		(mode == BPM_OFF)[*2] |-> !aux_regulator_one && !measure_en && settings_lost)
		else $error("off mode not fully down");
	chk_idle_flag: assert property (
		1'b1 |=> idle_active == ($past(mode) == BPM_IDLE))
		else $error("idle status wrong");
	chk_fault_exit: assert property (
		mode == BPM_IDLE && protection_fault |-> ##[1:3] mode != BPM_IDLE)
		else $error("fault did not end idle");
	// Eight cycles is far below one second, so this only catches a missing hold-off
	chk_hyst_block: assert property (
		$past(mode) == BPM_IDLE && mode == BPM_ACTIVE && hyst_sec != 8'h00
			|-> (mode != BPM_IDLE)[*8]) else $error("idle re-entered too soon");
	chk_no_permit: assert property (
		mode == BPM_ACTIVE ##1 mode == BPM_IDLE |-> idle_permitted)
		else $error("idle entered without permit");
	chk_osc_rate: assert property (
		mode == $past(mode) && (mode == BPM_ACTIVE || mode == BPM_IDLE) |-> slow_oscillator_en
			&& slow_oscillator_fast == (mode == BPM_ACTIVE)) else $error("slow osc rate wrong");
endmodule : bpm_mode_asserts

// *** bpm_host.sv ***
`timescale 1ns/10ps
module bpm_host (
	input  wire logic       clk,
	output logic      [7:0] cmd
);
	initial cmd = 8'h00;
	// One-cycle pulse launched on an edge; returns just past the edge that drops it
	task send(input int k);
		@(posedge clk) cmd <= 8'h01 << k[2:0];
		@(posedge clk) cmd <= 8'h00;
		#1;
	endtask : send
endmodule : bpm_host

// *** bpm_mode_ctrl_tb.sv ***
`timescale 1ns/10ps
module bpm_mode_ctrl_tb;
	import bpm_pkg::*;
	localparam int ALLOW = 0, EXIT = 2, DEEP_IN = 3, DEEP_OUT = 4, SHUT = 5;
	logic clk = 0, sys_rst = 1, init_done = 0, idle_permit_strap = 0, fast_conv_en = 0;
	logic idle_cc_valid = 0, protection_fault = 0, charger_attach_pin = 0, rst_shut_pin = 0;
	logic idle_dsg_follow = 1, idle_chg_on = 0, deep_slow_osc_on = 1, deep_regs_on = 1;
	logic fast_osc_req = 0;
	logic [2:0] volt_period_mult = 3'h0;
	logic [7:0] idle_interval_sec = 8'h01, hyst_sec = 8'h02, cmd;
	// Relax below 0x10, wake above 0x40
	logic [15:0] relax_thresh = 16'h0010, wake_thresh = 16'h0040, pack_delta = 16'h0010;
	logic [15:0] stack_thresh = 16'h0200, coarse_current_sample = 16'h0100;
	logic [15:0] idle_cc_sample = 16'h0000, pack_voltage = 16'h0100, stack_voltage = 16'h0100;
	wire cmd_idle_allow, cmd_idle_forbid, cmd_idle_exit, cmd_deep_enter, cmd_deep_exit;
	wire cmd_shutdown, cmd_update_enter, cmd_update_exit;
	bpm_mode_t mode;
	bpm_dsg_t discharge_switch;
	logic idle_permitted, idle_active, cur_sample_go, volt_sample_go, fine_sample_go;
	logic temp_eval_go, comparators_en, measure_en, charge_switch, precharge_switch;
	logic predischarge_switch, slow_oscillator_en, slow_oscillator_fast, fast_oscillator_en;
	logic aux_regulator_one, aux_regulator_two, settings_lost;
	int n_fail = 0, checks = 0, c;
	assign {cmd_update_exit, cmd_update_enter, cmd_shutdown, cmd_deep_exit, cmd_deep_enter,
		cmd_idle_exit, cmd_idle_forbid, cmd_idle_allow} = cmd;
	bpm_mode_ctrl #(.SEC_CYCLES(100), .CUR_CYCLES(10), .VOLT_CYCLES(40), .IDLE_CC_CYCLES(20))
		u_bpm_mode_ctrl (.*);
	bpm_host u_bpm_host (.clk, .cmd);
	always #12.5 clk = ~clk;
	task check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task wait_mode(input bpm_mode_t m, input int lim);
		#1;
		for (int i = 0; i < lim && mode !== m; i++) begin
			@(posedge clk);
			#1;
		end
		check(mode, m);
	endtask : wait_mode
	task count(input int n, input int sel);
		c = 0;
		repeat (n) begin
			@(posedge clk);
			#1 c += (sel == 0) ? cur_sample_go : (sel == 1) ? volt_sample_go
				: (sel == 2) ? fine_sample_go : temp_eval_go;
		end
	endtask : count
	task test_done;
		if (n_fail == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
	initial begin
		#400000;
		n_fail++;
		test_done;
	end
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1 check(mode, BPM_INIT);
		@(posedge clk) init_done <= 1'b1;
		wait_mode(BPM_ACTIVE, 3);
		repeat (2) @(posedge clk);
		#1 check(measure_en, 1'b1);
		check(idle_permitted, 1'b0);
		count(100, 0);
		check(c[15:0], 16'h000a);
		count(100, 2);
		check(c[15:0], 16'h000a);
		count(400, 3);
		check(c[15:0], 16'h000a);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) volt_period_mult <= (k == 1) ? 3'h1 : 3'h0;
			fast_conv_en <= (k == 2);
			count(80, 1);
			count(400, 1);
			check(c[15:0], (k == 1) ? 16'h0005 : (k == 2) ? 16'h0014 : 16'h000a);
		end
		@(posedge clk) fast_conv_en <= 1'b0;
		coarse_current_sample <= 16'h0000;
		repeat (20) @(posedge clk);
		#1 check(mode, BPM_ACTIVE);
		u_bpm_host.send(ALLOW);
		wait_mode(BPM_IDLE, 6);
		repeat (2) @(posedge clk);
		#1 check(idle_active, 1'b1);
		check(discharge_switch, BPM_DSG_FOLLOW);
		check(charge_switch, 1'b0);
		check(comparators_en, 1'b1);
		check(slow_oscillator_fast, 1'b0);
		count(100, 0);
		check(c[15:0], 16'h0005);
		count(200, 3);
		check(c[15:0], 16'h0002);
		count(100, 2);
		check(c[15:0], 16'h0000);
		for (int k = 0; k < 7; k++) begin
			@(posedge clk);
			case (k)
				0: u_bpm_host.send(EXIT);
				1: idle_cc_sample <= 16'h0080;
				2: pack_voltage <= 16'h0200;
				3: protection_fault <= 1'b1;
				4: charger_attach_pin <= 1'b1;
				5: begin
					rst_shut_pin <= 1'b1;
					repeat (3) @(posedge clk);
					rst_shut_pin <= 1'b0;
				end
				default: coarse_current_sample <= 16'h0080;
			endcase
			idle_cc_valid <= (k == 1);
			@(posedge clk) idle_cc_valid <= 1'b0;
			wait_mode(BPM_ACTIVE, (k == 2 || k == 6) ? 250 : 10);
			@(posedge clk) idle_cc_sample <= 16'h0000;
			pack_voltage <= 16'h0100;
			protection_fault <= 1'b0;
			charger_attach_pin <= 1'b0;
			#1 check(discharge_switch, BPM_DSG_PUMP);
			if (k == 0) begin
				repeat (95) @(posedge clk);
				#1 check(mode, BPM_ACTIVE);
			end
			if (k < 6) wait_mode(BPM_IDLE, 300);
		end
		@(posedge clk) fast_osc_req <= 1'b1;
		u_bpm_host.send(DEEP_IN);
		wait_mode(BPM_DEEP, 4);
		repeat (2) @(posedge clk);
		#1 check(discharge_switch, BPM_DSG_OFF);
		check(aux_regulator_one, 1'b1);
		check(aux_regulator_two, 1'b1);
		check(measure_en, 1'b0);
		check(precharge_switch, 1'b0);
		check(predischarge_switch, 1'b0);
		check(slow_oscillator_en, 1'b1);
		check(fast_oscillator_en, 1'b1);
		u_bpm_host.send(DEEP_OUT);
		wait_mode(BPM_ACTIVE, 4);
		u_bpm_host.send(SHUT);
		wait_mode(BPM_OFF, 4);
		repeat (2) @(posedge clk);
		#1 check(settings_lost, 1'b1);
		check(aux_regulator_one, 1'b0);
		check(aux_regulator_two, 1'b0);
		check(slow_oscillator_en, 1'b0);
		check(fast_oscillator_en, 1'b0);
		test_done;
	end
endmodule : bpm_mode_ctrl_tb
bind bpm_mode_ctrl bpm_mode_asserts u_chk (.*);
